// ==== hdl/pfs_pkg.sv ====
/*
  Constants and types for the power fault supervisor.
  Assumes a single 100 MHz system clock.
*/
package pfs_pkg;
  localparam int NBUCK     = 4;
  localparam int CLK_MHZ   = 100;
  localparam int T_REG_MS  = 14;
  localparam int T_SYS_MS  = 100;
  localparam int US_PER_MS = 1000;
  localparam int OC_CYCLES = 16;
  localparam int OCW       = 5;
  localparam logic [OCW-1:0] OC_SAT = 5'h11;
  localparam int THRW      = 8;
  localparam logic [THRW-1:0] THR_DEFAULT = 8'h80;
  localparam int REGCW     = 21;
  localparam int SYSCW     = 24;

  // Comparator inputs, all asynchronous to clk_sys
  typedef struct packed {
    logic [NBUCK-1:0] oc_warn;
    logic [NBUCK-1:0] oc_limit;
    logic [NBUCK-1:0] oc_crit;
    logic [NBUCK-1:0] uv;
    logic [NBUCK-1:0] sw_cycle;
    logic             twarn;
    logic             tshut;
  } pfs_cmp_t;

  typedef struct packed {
    logic [NBUCK-1:0] oc;
    logic [NBUCK-1:0] uv;
    logic             twarn;
    logic             tshut;
  } pfs_mask_t;

  typedef enum logic [1:0] {
    ST_RESET,
    ST_ACTIVE,
    ST_OFF_WAIT
  } pfs_state_t;
endpackage

// ==== hdl/pfs_supervisor.sv ====
/*
  Fault supervisor: power cycle, overcurrent levels, thermal handling.
  Assumes comparator pins are asynchronous and control ports come from
  register logic on clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
module pfs_supervisor #(
  parameter int REG_CYC = pfs_pkg::T_REG_MS * pfs_pkg::US_PER_MS
                          * pfs_pkg::CLK_MHZ,
  parameter int SYS_CYC = pfs_pkg::T_SYS_MS * pfs_pkg::US_PER_MS
                          * pfs_pkg::CLK_MHZ
) (
  input  wire logic                       clk_sys,
  input  wire logic                       rst_n,
  input  wire pfs_pkg::pfs_cmp_t          cmp_pin,
  input  wire pfs_pkg::pfs_mask_t         mask,
  input  wire logic                       mpc_write,
  input  wire logic                       thr_write,
  input  wire logic [1:0]                 thr_sel,
  input  wire logic [pfs_pkg::THRW-1:0]   thr_data,
  output logic                            manual_power_cycle_bit,
  output logic [pfs_pkg::NBUCK-1:0]       reg_en,
  output logic [pfs_pkg::NBUCK-1:0]       ton_end,
  output logic [pfs_pkg::NBUCK*pfs_pkg::THRW-1:0] ocl_threshold,
  output logic [pfs_pkg::NBUCK-1:0]       oc_flag,
  output logic [pfs_pkg::NBUCK-1:0]       uv_flag,
  output logic                            twarn_flag,
  output logic                            tshut_flag,
  output pfs_pkg::pfs_state_t             pwr_state,
  output logic                            interrupt_request_n
);
  localparam int NB = pfs_pkg::NBUCK;

  logic              rst_m;
  logic              rst_s_n;
  pfs_pkg::pfs_cmp_t cmp_m;
  pfs_pkg::pfs_cmp_t cmp_s;
  logic [NB-1:0]     sw_d;
  logic [NB-1:0]     hold;
  localparam int SYSCW_L = pfs_pkg::SYSCW;
  logic [SYSCW_L-1:0] sys_cnt;
  logic              sys_evt;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_m   <= 1'b0;
      rst_s_n <= 1'b0;
    end else begin
      rst_m   <= 1'b1;
      rst_s_n <= rst_m;
    end
  end

  // Two-stage synchroniser; only cmp_s is read by logic
  always_ff @(posedge clk_sys or negedge rst_s_n) begin
    if (!rst_s_n) begin
      cmp_m <= '0;
      cmp_s <= '0;
      sw_d  <= '0;
    end else begin
      cmp_m <= cmp_pin;
      cmp_s <= cmp_m;
      sw_d  <= cmp_s.sw_cycle;
    end
  end

  assign sys_evt = (|(cmp_s.uv & ~mask.uv))
                   || (cmp_s.tshut && !mask.tshut);

  // Power state machine
  always_ff @(posedge clk_sys or negedge rst_s_n) begin
    if (!rst_s_n) begin
      pwr_state <= pfs_pkg::ST_RESET;
      sys_cnt   <= '0;
    end else if (manual_power_cycle_bit) begin
      pwr_state <= pfs_pkg::ST_RESET;
    end else begin
      case (pwr_state)
        pfs_pkg::ST_RESET: begin
          pwr_state <= pfs_pkg::ST_ACTIVE;
        end
        pfs_pkg::ST_ACTIVE: begin
          if (sys_evt) begin
            pwr_state <= pfs_pkg::ST_OFF_WAIT;
            sys_cnt   <= SYSCW_L'(SYS_CYC - 1);
          end
        end
        pfs_pkg::ST_OFF_WAIT: begin
          if (sys_evt) begin
            sys_cnt <= SYSCW_L'(SYS_CYC - 1);
          end else if (sys_cnt == '0) begin
            pwr_state <= pfs_pkg::ST_RESET;
          end else begin
            sys_cnt <= sys_cnt - 1'b1;
          end
        end
        default: begin
          pwr_state <= pfs_pkg::ST_RESET;
        end
      endcase
    end
  end

  // Set by a write wins over the clear by execution
  always_ff @(posedge clk_sys or negedge rst_s_n) begin
    if (!rst_s_n) begin
      manual_power_cycle_bit <= 1'b0;
    end else if (mpc_write) begin
      manual_power_cycle_bit <= 1'b1;
    end else if (manual_power_cycle_bit) begin
      manual_power_cycle_bit <= 1'b0;
    end
  end

  // Thresholds reload while in reset so restart uses defaults
  always_ff @(posedge clk_sys or negedge rst_s_n) begin
    if (!rst_s_n) begin
      ocl_threshold <= {NB{pfs_pkg::THR_DEFAULT}};
    end else if (pwr_state == pfs_pkg::ST_RESET) begin
      ocl_threshold <= {NB{pfs_pkg::THR_DEFAULT}};
    end else if (thr_write) begin
      ocl_threshold[thr_sel*pfs_pkg::THRW +: pfs_pkg::THRW] <= thr_data;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NB; gi++) begin : g_buck
      logic [pfs_pkg::OCW-1:0]   occ;
      logic [pfs_pkg::REGCW-1:0] rcnt;

      // Consecutive switching cycles at the warning level
      always_ff @(posedge clk_sys or negedge rst_s_n) begin
        if (!rst_s_n) begin
          occ <= '0;
        end else if (cmp_s.sw_cycle[gi] && !sw_d[gi]) begin
          if (!cmp_s.oc_warn[gi]) begin
            occ <= '0;
          end else if (occ != pfs_pkg::OC_SAT) begin
            occ <= occ + 1'b1;
          end
        end
      end

      // Mask is not consulted here: protection is always on
      always_ff @(posedge clk_sys or negedge rst_s_n) begin
        if (!rst_s_n) begin
          hold[gi] <= 1'b0;
          rcnt     <= '0;
        end else if (cmp_s.oc_crit[gi]) begin
          hold[gi] <= 1'b1;
          rcnt     <= pfs_pkg::REGCW'(REG_CYC - 1);
        end else if (hold[gi]) begin
          if (rcnt == '0) begin
            hold[gi] <= 1'b0;
          end else begin
            rcnt <= rcnt - 1'b1;
          end
        end
      end

      always_ff @(posedge clk_sys or negedge rst_s_n) begin
        if (!rst_s_n) begin
          oc_flag[gi] <= 1'b0;
          uv_flag[gi] <= 1'b0;
          ton_end[gi] <= 1'b0;
          reg_en[gi]  <= 1'b0;
        end else begin
          oc_flag[gi] <= occ > pfs_pkg::OCW'(pfs_pkg::OC_CYCLES);
          uv_flag[gi] <= cmp_s.uv[gi];
          ton_end[gi] <= cmp_s.oc_limit[gi];
          reg_en[gi]  <= (pwr_state == pfs_pkg::ST_ACTIVE) && !hold[gi]
                         && !manual_power_cycle_bit;
        end
      end
    end
  endgenerate

  // Flags follow live state; masks gate the interrupt, and the uv and tshut masks also gate the power-off event
  always_ff @(posedge clk_sys or negedge rst_s_n) begin
    if (!rst_s_n) begin
      twarn_flag <= 1'b0;
      tshut_flag <= 1'b0;
    end else begin
      twarn_flag <= cmp_s.twarn;
      tshut_flag <= cmp_s.tshut;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_s_n) begin
    if (!rst_s_n) begin
      interrupt_request_n <= 1'b1;
    end else begin
      interrupt_request_n <= !((|(oc_flag & ~mask.oc))
                             || (|(uv_flag & ~mask.uv))
                             || (twarn_flag && !mask.twarn)
                             || (tshut_flag && !mask.tshut));
    end
  end

  sequence s_all_off;
    ##1 (reg_en == '0);
  endsequence

  property p_mpc_reset;
    @(posedge clk_sys) disable iff (!rst_s_n)
    manual_power_cycle_bit |=> (pwr_state == pfs_pkg::ST_RESET)
                               and (reg_en == '0);
  endproperty
  a_mpc_reset: assert property (p_mpc_reset) else $error("no reset");

  property p_mpc_clear;
    @(posedge clk_sys) disable iff (!rst_s_n)
    manual_power_cycle_bit && !mpc_write |=> !manual_power_cycle_bit;
  endproperty
  a_mpc_clear: assert property (p_mpc_clear) else $error("bit kept");

  property p_oc_flag;
    @(posedge clk_sys) disable iff (!rst_s_n)
    $rose(oc_flag[0]) |-> $past(g_buck[0].occ, 1) == pfs_pkg::OC_SAT;
  endproperty
  a_oc_flag: assert property (p_oc_flag) else $error("early flag");

  property p_oc_irq;
    @(posedge clk_sys) disable iff (!rst_s_n)
    oc_flag[0] && !mask.oc[0] |=> !interrupt_request_n;
  endproperty
  a_oc_irq: assert property (p_oc_irq) else $error("irq missing");

  property p_limit;
    @(posedge clk_sys) disable iff (!rst_s_n)
    cmp_s.oc_limit[1] |=> ton_end[1];
  endproperty
  a_limit: assert property (p_limit) else $error("no on-time end");

  property p_uv_off;
    @(posedge clk_sys) disable iff (!rst_s_n)
    pwr_state == pfs_pkg::ST_ACTIVE && !manual_power_cycle_bit
      && |(cmp_s.uv & ~mask.uv)
      |=> (pwr_state == pfs_pkg::ST_OFF_WAIT) ##0 s_all_off;
  endproperty
  a_uv_off: assert property (p_uv_off) else $error("uv not off");

  property p_crit;
    @(posedge clk_sys) disable iff (!rst_s_n)
    cmp_s.oc_crit[2] |=> hold[2] ##1 !reg_en[2];
  endproperty
  a_crit: assert property (p_crit) else $error("crit not off");

  property p_crit_masked;
    @(posedge clk_sys) disable iff (!rst_s_n)
    cmp_s.oc_crit[2] && mask.oc[2] |=> hold[2];
  endproperty
  a_crit_masked: assert property (p_crit_masked) else $error("masked");

  property p_twarn;
    @(posedge clk_sys) disable iff (!rst_s_n)
    (cmp_s.twarn && !mask.twarn)[*2] |=> !interrupt_request_n;
  endproperty
  a_twarn: assert property (p_twarn) else $error("warn irq");

  property p_tshut;
    @(posedge clk_sys) disable iff (!rst_s_n)
    pwr_state == pfs_pkg::ST_ACTIVE && !manual_power_cycle_bit
      && cmp_s.tshut && !mask.tshut |=> pwr_state == pfs_pkg::ST_OFF_WAIT;
  endproperty
  a_tshut: assert property (p_tshut) else $error("tshut ignored");

  property p_live;
    @(posedge clk_sys) disable iff (!rst_s_n)
    mask.tshut && cmp_s.tshut |=> tshut_flag;
  endproperty
  a_live: assert property (p_live) else $error("flag not live");

  property p_reload;
    @(posedge clk_sys) disable iff (!rst_s_n)
    pwr_state == pfs_pkg::ST_RESET |=>
      ocl_threshold == {NB{pfs_pkg::THR_DEFAULT}};
  endproperty
  a_reload: assert property (p_reload) else $error("no reload");
endmodule
`default_nettype wire

// ==== tb/pfs_analog.sv ====
/*
  Comparator model standing in for the analog front end.
  Assumes the bench sets the comparator levels; switching edges
  run only while the bench asks for them.
*/
`timescale 1ns/1ps
`default_nettype none
module pfs_analog (
  input  wire logic              clk_sys,
  input  wire logic              run,
  input  wire pfs_pkg::pfs_cmp_t lvl,
  output pfs_pkg::pfs_cmp_t      cmp_pin
);
  logic [1:0] div = 2'h0;
  // Slow edges so the two-flop sync never drops one
  always @(posedge clk_sys) begin
    div <= run ? div + 2'h1 : 2'h0;
  end
  always_comb begin
    cmp_pin          = lvl;
    cmp_pin.sw_cycle = {pfs_pkg::NBUCK{div[1]}};
  end
endmodule
`default_nettype wire

// ==== tb/pfs_supervisor_bench.sv ====
/*
  Self-checking bench for the fault supervisor.
  Assumes shortened restart counts and the comparator model.
*/
`timescale 1ns/1ps
`default_nettype none
module pfs_supervisor_bench;
  logic               clk_sys = 1'b0;
  logic               rst_n = 1'b0;
  logic               run = 1'b0;
  logic               mpc_write = 1'b0;
  logic               thr_write = 1'b0;
  logic [1:0]         thr_sel = 2'h0;
  logic [7:0]         thr_data = 8'h00;
  pfs_pkg::pfs_cmp_t  lvl = '0;
  pfs_pkg::pfs_cmp_t  cmp_pin;
  pfs_pkg::pfs_mask_t mask = '0;
  logic               mpc_bit, tw, ts, irq_n;
  logic [3:0]         reg_en, ton_end, oc_flag, uv_flag;
  logic [31:0]        thr;
  pfs_pkg::pfs_state_t st;
  int                 errors = 0;
  int                 cmp_count = 0;
  always #5 clk_sys = ~clk_sys;
  pfs_analog ana (.clk_sys(clk_sys), .run(run), .lvl(lvl),
                  .cmp_pin(cmp_pin));
  pfs_supervisor #(.REG_CYC(20), .SYS_CYC(50)) uut (
    .clk_sys(clk_sys), .rst_n(rst_n), .cmp_pin(cmp_pin),
    .mask(mask), .mpc_write(mpc_write), .thr_write(thr_write),
    .thr_sel(thr_sel), .thr_data(thr_data),
    .manual_power_cycle_bit(mpc_bit), .reg_en(reg_en),
    .ton_end(ton_end), .ocl_threshold(thr), .oc_flag(oc_flag),
    .uv_flag(uv_flag), .twarn_flag(tw), .tshut_flag(ts),
    .pwr_state(st), .interrupt_request_n(irq_n));
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic done(input string s);
    $display("test %s done", s);
  endtask
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Whole run needs well under a thousand cycles
  initial begin
    repeat (3000) @(posedge clk_sys);
    errors++;
    tally_and_finish();
  end
  initial begin
    tick(16);
    rst_n = 1'b1;
    tick(6);
    chk(reg_en, 4'hf);
    chk(irq_n, 1'b1);
    thr_sel = 2'h2;
    thr_data = 8'h3c;
    thr_write = 1'b1;
    tick(1);
    thr_write = 1'b0;
    tick(1);
    chk(thr, 32'h803c8080);
    mpc_write = 1'b1;
    tick(1);
    mpc_write = 1'b0;
    chk(mpc_bit, 1'b1);
    tick(1);
    chk(mpc_bit, 1'b0);
    chk(reg_en, 4'h0);
    chk(st, pfs_pkg::ST_RESET);
    tick(2);
    chk(reg_en, 4'hf);
    chk(thr, 32'h80808080);
    done("power cycle");
    lvl.oc_warn = 4'h1;
    run = 1'b1;
    tick(68);
    chk(oc_flag, 4'h0);
    tick(12);
    chk(oc_flag, 4'h1);
    chk(irq_n, 1'b0);
    mask.oc = 4'hf;
    tick(3);
    chk(irq_n, 1'b1);
    chk(oc_flag, 4'h1);
    lvl.oc_warn = 4'h0;
    lvl.oc_limit = 4'h2;
    tick(5);
    chk(ton_end, 4'h2);
    lvl.oc_limit = 4'h0;
    lvl.oc_crit = 4'h4;
    tick(6);
    chk(reg_en, 4'hb);
    lvl.oc_crit = 4'h0;
    run = 1'b0;
    mask.oc = 4'h0;
    tick(10);
    chk(reg_en, 4'hb);
    lvl.oc_crit = 4'h4;
    tick(2);
    lvl.oc_crit = 4'h0;
    tick(15);
    chk(reg_en, 4'hb);
    tick(20);
    chk(reg_en, 4'hf);
    done("overcurrent");
    mask.uv = 4'h8;
    lvl.uv = 4'h8;
    tick(6);
    chk(uv_flag, 4'h8);
    chk(st, pfs_pkg::ST_ACTIVE);
    mask.uv = 4'h0;
    tick(4);
    chk(st, pfs_pkg::ST_OFF_WAIT);
    chk(reg_en, 4'h0);
    lvl.uv = 4'h0;
    tick(30);
    chk(st, pfs_pkg::ST_OFF_WAIT);
    tick(40);
    chk(reg_en, 4'hf);
    done("undervoltage");
    lvl.twarn = 1'b1;
    tick(5);
    chk(tw, 1'b1);
    chk(irq_n, 1'b0);
    mask.twarn = 1'b1;
    tick(2);
    chk(irq_n, 1'b1);
    chk(tw, 1'b1);
    mask.tshut = 1'b1;
    lvl.tshut = 1'b1;
    tick(5);
    chk(ts, 1'b1);
    chk(reg_en, 4'hf);
    mask.tshut = 1'b0;
    tick(3);
    chk(reg_en, 4'h0);
    chk(irq_n, 1'b0);
    lvl = '0;
    tick(70);
    chk(st, pfs_pkg::ST_ACTIVE);
    done("thermal");
    tally_and_finish();
  end
endmodule
`default_nettype wire
